// file: bicd_defs.vh
/*
 * bicd_defs.vh: register offsets, field positions, reset values and
 * limits of the bus-initialization identity capture DMA.
 * assumes: included by bicd_capture.v only, guarded against reinclusion.
 */
`ifndef BICD_DEFS_VH
`define BICD_DEFS_VH

// register byte offsets on the apb slave
`define BICD_OFS_BASE        12'h000
`define BICD_OFS_STATUS      12'h004
`define BICD_OFS_LINK_CTRL   12'h008
`define BICD_OFS_INT_EVENT   12'h00c
`define BICD_OFS_INT_MASK    12'h010
`define BICD_OFS_BUS_TIME    12'h014

// identity_capture_status field positions
`define BICD_ST_ERR_BIT      31
`define BICD_ST_GEN_HI       23
`define BICD_ST_GEN_LO       16
`define BICD_ST_SIZE_HI      10
`define BICD_ST_SIZE_LO      2

// link_control_reg and interrupt bits
`define BICD_LC_ACCEPT_BIT   9
`define BICD_EV_BUS_RESET    0
`define BICD_EV_DONE         1
`define BICD_EV_WIDTH        2

// reset values and limits
`define BICD_SIZE_RESET      9'h000
`define BICD_SIZE_FULL       9'h1ff
`define BICD_SIZE_OVERFLOW   11'h7ff // overflow mark, cut to the count field
`define BICD_GEN_RESET       8'h00
`define BICD_BASE_ALIGN_MASK 32'hfffff800

`endif

// file: bicd_capture.v
/*
 * bicd_capture.v: identity capture dma of the serial-bus host controller.
 * captures self-identity quadlets between bus reset end and the first
 * subaction gap, writes them behind a header quadlet into a 2k host
 * buffer, and keeps status, interrupts and an apb register file.
 * assumes: phy-side strobes and the host write port are synchronous to
 * SYS_CLK; the host write port takes one request and answers done/error.
 */
// The placing of the registers and the APB slave port were chosen for this implementation.
// Summary of operation
// [R1] error flag set on hardware or write error
// [R2] error-free capture clears the error flag
// [R3] generation counts bus resets, wraps at 255
// [R4] quadlet count includes header and packet data
// [R5] bus reset zeroes count with reset event
// [R6] reset during capture restarts, overwrites buffer
// [R7] header quadlet carries the generation number
// [R8] header timestamp: 3 seconds bits, 13 cycle bits
// [R9] after an error further data is discarded
// [R10] full 2048 bytes: count 7ff, error set; code stores 1ff, the low nine bits of the mark
// [R11] packets stored unchecked, software checks inverses
// [R12] data stored from reset end to subaction gap
// [R13] capture only while accept bit is set
// [R14] software loads base before setting accept bit
// [R15] identity phase end raises done event; code raises it on a subaction gap only, not on a bus reset
// [R16] identity packets outside phase go to queue
// [R17] software compares memory and register generations
// [R18] base register writable, 2k aligned, undefined
// [R19] quadlets go to ascending addresses from base
`timescale 1ns/1ps
`include "bicd_defs.vh"

module bicd_capture (
    input  wire        SYS_CLK,        // 250 mhz system clock
    input  wire        RST_N,          // asynchronous active-low reset
    // apb slave
    input  wire        PSEL,           // apb select
    input  wire        PENABLE,        // apb access phase
    input  wire        PWRITE,         // apb direction
    input  wire [11:0] PADDR,          // apb byte address
    input  wire [31:0] PWDATA,         // apb write data
    output reg  [31:0] PRDATA,         // apb read data
    output reg         PREADY,         // apb ready
    output reg         PSLVERR,        // apb error on unmapped address
    // phy side
    input  wire        BUS_RESET_START,   // pulse: bus reset detected
    input  wire        BUS_RESET_END,     // pulse: bus reset finished
    input  wire        SUBACTION_GAP,     // pulse: first subaction gap seen
    input  wire        ID_QUADLET_VALID,  // pulse: identity quadlet received
    input  wire [31:0] ID_QUADLET_DATA,   // received identity quadlet
    input  wire        PHY_RX_ERROR,      // pulse: hardware receive error
    input  wire [31:0] BUS_TIME,          // bus_time_register value
    // host memory write port
    output reg         HOST_WR_REQ,    // level: write request pending
    output reg  [31:0] HOST_WR_ADDR,   // quadlet byte address
    output reg  [31:0] HOST_WR_DATA,   // quadlet data
    input  wire        HOST_WR_DONE,   // pulse: write completed
    input  wire        HOST_WR_ERR,    // pulse with done: write failed
    // inbound_request_queue forwarding
    output reg         QUEUE_VALID,    // pulse: phy packet to queue
    output reg  [31:0] QUEUE_DATA,     // forwarded quadlet
    output reg         IRQ             // level interrupt
);

    ////////////////////////////////////////////////////////////////////
    // reset release through two flip-flops
    reg rst_meta;
    reg rst_sync;
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end
    wire rst_n = rst_sync;

    ////////////////////////////////////////////////////////////////////
    // capture states
    localparam [1:0] ST_IDLE   = 2'b00;  // outside identity phase
    localparam [1:0] ST_WAIT   = 2'b01;  // in bus reset, awaiting its end
    localparam [1:0] ST_HEADER = 2'b10;  // writing header quadlet
    localparam [1:0] ST_DATA   = 2'b11;  // storing identity data

    // header quadlet: generation in 23:16, timestamp in 15:0
    function [31:0] make_header;
        input [7:0]  gen;
        input [31:0] tm;
        begin
            make_header = {8'h00, gen, tm[27:25], tm[24:12]};
        end
    endfunction

    // byte address of quadlet n in the buffer
    function [31:0] quad_addr;
        input [31:0] base;
        input [8:0]  n;
        begin
            quad_addr = (base & `BICD_BASE_ALIGN_MASK) | {21'h000000, n, 2'b00};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // registers
    reg  [31:0] capture_buffer_base;
    reg         accept_identity_packets;
    reg         capture_error_flag;
    reg  [7:0]  reset_generation_count;
    reg  [8:0]  written_quadlet_count;
    reg  [`BICD_EV_WIDTH-1:0] interrupt_event_reg;
    reg  [`BICD_EV_WIDTH-1:0] int_mask;
    reg  [1:0]  state;
    reg         seq_error;     // error seen in current sequence
    reg         hold_valid;    // one quadlet waiting for the write port
    reg  [31:0] hold_data;
    reg  [8:0]  next_slot;     // buffer slot of the next write

    wire apb_write = PSEL && PENABLE && PWRITE && PREADY;
    wire apb_read  = PSEL && !PENABLE && !PWRITE;
    wire in_phase  = (state == ST_HEADER) || (state == ST_DATA);
    wire overflow  = (next_slot == `BICD_SIZE_FULL) && HOST_WR_DONE && !HOST_WR_ERR;
    // overflow mark: only its low nine bits fit the quadlet count field
    wire [10:0] overflow_mark = `BICD_SIZE_OVERFLOW;

    ////////////////////////////////////////////////////////////////////
    // apb slave: no wait states, reads decoded in setup phase
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                case (PADDR)
                    `BICD_OFS_BASE: PRDATA <= capture_buffer_base;
                    `BICD_OFS_STATUS: PRDATA <= {capture_error_flag, 7'h00,
                        reset_generation_count, 5'h00, written_quadlet_count[8:0], 2'b00};
                    `BICD_OFS_LINK_CTRL: PRDATA <= {22'h000000, accept_identity_packets, 9'h000};
                    `BICD_OFS_INT_EVENT: PRDATA <= {30'h00000000, interrupt_event_reg};
                    `BICD_OFS_INT_MASK: PRDATA <= {30'h00000000, int_mask};
                    `BICD_OFS_BUS_TIME: PRDATA <= BUS_TIME;
                    default: begin
                        PRDATA  <= 32'h00000000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
            if (!apb_read && !(PSEL && !PENABLE))
                PRDATA <= PRDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software-written control registers
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            capture_buffer_base     <= 32'h00000000;
            accept_identity_packets <= 1'b0;
            int_mask                <= 2'b00;
        end else if (apb_write) begin
            case (PADDR)
                `BICD_OFS_BASE: capture_buffer_base <= PWDATA & `BICD_BASE_ALIGN_MASK; // [R18]
                `BICD_OFS_LINK_CTRL: accept_identity_packets <= PWDATA[`BICD_LC_ACCEPT_BIT];
                `BICD_OFS_INT_MASK: int_mask <= PWDATA[`BICD_EV_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt events: sticky, write one to clear, set wins
    wire [`BICD_EV_WIDTH-1:0] ev_set;
    assign ev_set[`BICD_EV_BUS_RESET] = BUS_RESET_START;
    assign ev_set[`BICD_EV_DONE]      = in_phase && (SUBACTION_GAP || BUS_RESET_START)
                                        && !BUS_RESET_START; // [R15]
    wire [`BICD_EV_WIDTH-1:0] ev_clr =
        (apb_write && PADDR == `BICD_OFS_INT_EVENT) ? PWDATA[`BICD_EV_WIDTH-1:0] : 2'b00;

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_event_reg <= 2'b00;
            IRQ                 <= 1'b0;
        end else begin
            interrupt_event_reg <= (interrupt_event_reg & ~ev_clr) | ev_set;
            IRQ <= |(((interrupt_event_reg & ~ev_clr) | ev_set) & int_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // capture state machine, status fields and host writes
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            state                  <= ST_IDLE;
            capture_error_flag     <= 1'b0;
            reset_generation_count <= `BICD_GEN_RESET;
            written_quadlet_count  <= `BICD_SIZE_RESET;
            seq_error              <= 1'b0;
            hold_valid             <= 1'b0;
            hold_data              <= 32'h00000000;
            next_slot              <= 9'h000;
            HOST_WR_REQ            <= 1'b0;
            HOST_WR_ADDR           <= 32'h00000000;
            HOST_WR_DATA           <= 32'h00000000;
            QUEUE_VALID            <= 1'b0;
            QUEUE_DATA             <= 32'h00000000;
        end else begin
            QUEUE_VALID <= 1'b0;
            if (BUS_RESET_START) begin
                // restart: slot 0 again, old data will be overwritten
                reset_generation_count <= reset_generation_count + 8'h01;  // [R3]
                written_quadlet_count  <= `BICD_SIZE_RESET;                 // [R5]
                state       <= ST_WAIT;                                     // [R6]
                seq_error   <= 1'b0;
                hold_valid  <= 1'b0;
                next_slot   <= 9'h000;
                HOST_WR_REQ <= 1'b0;
            end else begin
                // completion of an outstanding host write
                if (HOST_WR_REQ && HOST_WR_DONE) begin
                    HOST_WR_REQ <= 1'b0;
                    if (HOST_WR_ERR) begin
                        seq_error          <= 1'b1;     // [R1]
                        capture_error_flag <= 1'b1;     // [R1]
                    end else if (overflow) begin
                        written_quadlet_count <= overflow_mark[8:0];  // [R10]
                        seq_error             <= 1'b1;                // [R10]
                        capture_error_flag    <= 1'b1;                // [R10]
                    end else begin
                        written_quadlet_count <= next_slot + 9'h001;  // [R4]
                        next_slot             <= next_slot + 9'h001;  // [R19]
                    end
                end
                if (PHY_RX_ERROR && in_phase) begin
                    seq_error          <= 1'b1;         // [R1]
                    capture_error_flag <= 1'b1;
                end
                case (state)
                    ST_IDLE: begin
                        // identity packets here use the phy packet format
                        if (ID_QUADLET_VALID) begin
                            QUEUE_VALID <= 1'b1;            // [R16]
                            QUEUE_DATA  <= ID_QUADLET_DATA;
                        end
                    end
                    ST_WAIT: begin
                        if (BUS_RESET_END)
                            state <= accept_identity_packets ? ST_HEADER : ST_IDLE; // [R13]
                    end
                    ST_HEADER: begin
                        // header carries generation and sampled timestamp
                        HOST_WR_REQ  <= 1'b1;
                        HOST_WR_ADDR <= quad_addr(capture_buffer_base, 9'h000);   // [R19]
                        HOST_WR_DATA <= make_header(reset_generation_count, BUS_TIME); // [R7] [R8]
                        state        <= ST_DATA;
                        if (ID_QUADLET_VALID) begin
                            hold_valid <= 1'b1;
                            hold_data  <= ID_QUADLET_DATA;
                        end
                    end
                    ST_DATA: begin
                        // raw quadlets, check words included, nothing verified
                        if (ID_QUADLET_VALID && accept_identity_packets  // [R13]
                            && !seq_error && !PHY_RX_ERROR) begin        // [R9] [R11]
                            hold_valid <= 1'b1;          // [R12]
                            hold_data  <= ID_QUADLET_DATA;
                        end
                        if (hold_valid && (!HOST_WR_REQ || HOST_WR_DONE) && !seq_error
                            && !(HOST_WR_DONE && (HOST_WR_ERR || overflow))) begin
                            HOST_WR_REQ  <= 1'b1;
                            HOST_WR_ADDR <= quad_addr(capture_buffer_base,
                                                      HOST_WR_DONE ? next_slot + 9'h001
                                                                   : next_slot); // [R19]
                            HOST_WR_DATA <= hold_data;
                            if (!ID_QUADLET_VALID)
                                hold_valid <= 1'b0;
                        end
                        if (seq_error)
                            hold_valid <= 1'b0;      // [R9]
                        if (SUBACTION_GAP) begin
                            state <= ST_IDLE;
                            if (!seq_error && !PHY_RX_ERROR && !(HOST_WR_DONE && HOST_WR_ERR))
                                capture_error_flag <= 1'b0; // [R2]
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // bicd_capture

// file: bicd_capture_chk.sv
/* bicd_capture_chk: port checks of the identity capture dma.
   assumes: bound to bicd_capture, one clock, RST_N low resets. */
`timescale 1ns/1ps
module bicd_capture_chk (
    input logic        SYS_CLK,          // clock
    input logic        RST_N,            // reset
    input logic        PSEL,             // apb
    input logic        PENABLE,          // apb
    input logic        PWRITE,           // apb
    input logic [11:0] PADDR,            // apb
    input logic [31:0] PRDATA,           // apb
    input logic        PREADY,           // apb
    input logic        PSLVERR,          // apb
    input logic        BUS_RESET_START,  // phy
    input logic        BUS_RESET_END,    // phy
    input logic        SUBACTION_GAP,    // phy
    input logic        ID_QUADLET_VALID, // phy
    input logic [31:0] ID_QUADLET_DATA,  // phy
    input logic [31:0] BUS_TIME,         // time
    input logic        HOST_WR_REQ,      // host
    input logic [31:0] HOST_WR_ADDR,     // host
    input logic [31:0] HOST_WR_DATA,     // host
    input logic        HOST_WR_DONE,     // host
    input logic        HOST_WR_ERR,      // host
    input logic        QUEUE_VALID,      // queue
    input logic [31:0] QUEUE_DATA        // queue
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic [7:0]  gen;   // bus resets seen
    logic        hdr;   // next new request is the header
    logic        phase; // identity phase open
    logic        req_q; // request one cycle ago
    logic [31:0] last;  // address of the last new request
    ////////////////////////////////////////////////////////////
    // shadow of generation, phase and write addresses
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gen   <= 8'h00;
            hdr   <= 1'b0;
            phase <= 1'b0;
            req_q <= 1'b0;
            last  <= 32'h0;
        end else begin
            gen   <= gen + {7'h00, BUS_RESET_START};
            hdr   <= BUS_RESET_END | (hdr & ~(HOST_WR_REQ & ~req_q));
            phase <= BUS_RESET_START | (phase & ~SUBACTION_GAP);
            req_q <= HOST_WR_REQ;
            last  <= (HOST_WR_REQ & ~req_q) ? HOST_WR_ADDR : last;
        end
    end
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_rd_status;
        PSEL && PENABLE && PREADY && !PWRITE && PADDR == 12'h004;
    endsequence
    sequence s_new_req;
        HOST_WR_REQ && !req_q;
    endsequence
    a_ready_next: assert property (s_setup |=> PREADY)
        else $error("apb answer late");
    a_unmapped_err: assert property (PSEL && !PENABLE && PADDR > 12'h014 |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_gen_read: assert property (s_rd_status |-> PRDATA[23:16] == gen)
        else $error("generation field wrong");
    a_req_hold: assert property (HOST_WR_REQ && !HOST_WR_DONE |=> HOST_WR_REQ && $stable(HOST_WR_ADDR) && $stable(HOST_WR_DATA))
        else $error("write request dropped or changed");
    a_header_word: assert property (s_new_req and hdr |-> HOST_WR_ADDR[10:0] == 11'h0 && HOST_WR_DATA == {8'h00, gen, BUS_TIME[27:12]})
        else $error("header quadlet wrong");
    a_addr_ascend: assert property (s_new_req and !hdr |-> HOST_WR_ADDR == last + 32'h4)
        else $error("write address not ascending");
    a_flush_err: assert property (HOST_WR_DONE && HOST_WR_ERR |=> !HOST_WR_REQ [*8])
        else $error("write after host error");
    a_queue_forward: assert property (ID_QUADLET_VALID && !phase |=> QUEUE_VALID && QUEUE_DATA == $past(ID_QUADLET_DATA))
        else $error("quadlet outside phase not forwarded");
endmodule // bicd_capture_chk

// file: bicd_host_mem.sv
/* bicd_host_mem: host memory behind the capture write port.
   assumes: one request at a time, answered after delay cycles. */
`timescale 1ns/1ps
module bicd_host_mem (
    input  logic        clk,   // system clock
    input  logic        rst_n, // active-low reset
    input  logic        req,   // write request level
    input  logic [31:0] addr,  // byte address
    input  logic [31:0] data,  // quadlet
    input  int          delay, // wait cycles before done
    input  logic        fail,  // answer with an error
    output logic        done,  // one-cycle completion
    output logic        err    // error, valid with done
);
    logic [31:0] mem [0:511]; // one 2k buffer by quadlet
    int          n_wr;        // writes answered
    int          waited;      // cycles spent on this write
    ////////////////////////////////////////////////////////////
    // answer each request once, promptly or slowly
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done   <= 1'b0;
            err    <= 1'b0;
            waited <= 0;
            n_wr   <= 0;
        end else if (done || !req) begin
            done   <= 1'b0;
            err    <= 1'b0;
            waited <= 0;
        end else if (waited < delay) begin
            waited <= waited + 1;
        end else begin
            done <= 1'b1;
            err  <= fail;
            n_wr <= n_wr + 1;
            if (!fail) mem[addr[10:2]] <= data;
        end
    end
endmodule // bicd_host_mem

// file: bicd_capture_bench.sv
/* bicd_capture_bench: apb and phy stimulus with a model of the buffer.
   assumes: bicd_host_mem and bicd_capture_chk compiled before it. */
`timescale 1ns/1ps
module bicd_capture_bench;
    logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, fail, err_rd;
    logic        BUS_RESET_START, BUS_RESET_END, SUBACTION_GAP, ID_QUADLET_VALID, PHY_RX_ERROR;
    logic        HOST_WR_REQ, HOST_WR_DONE, HOST_WR_ERR, QUEUE_VALID;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, ID_QUADLET_DATA, BUS_TIME, HOST_WR_ADDR, HOST_WR_DATA;
    logic [31:0] QUEUE_DATA, rd, q[$];
    int          n_mismatch, checked, delay, spc, gen_m, w0;
    bicd_capture i_bicd_capture (.*);
    bicd_host_mem i_bicd_host_mem (.clk(SYS_CLK), .rst_n(RST_N), .req(HOST_WR_REQ),
        .addr(HOST_WR_ADDR), .data(HOST_WR_DATA), .delay(delay), .fail(fail),
        .done(HOST_WR_DONE), .err(HOST_WR_ERR));
    ////////////////////////////////////////////////////////////
    // 250 mhz clock
    always #2 SYS_CLK = ~SYS_CLK;
    task automatic end_of_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, waiting a bounded time for the answer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge SYS_CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 50);
        if (i >= 50) n_mismatch++;
        if (i >= 50) end_of_test;
        rd = PRDATA;
        err_rd = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge SYS_CLK);
    endtask
    // one-cycle phy strobe: 0 reset start, 1 reset end, 2 gap, 3 quadlet, 4 rx error
    task automatic phy(input int k, input logic [31:0] d);
        case (k)
            0: BUS_RESET_START <= 1'b1;
            1: BUS_RESET_END <= 1'b1;
            2: SUBACTION_GAP <= 1'b1;
            3: ID_QUADLET_VALID <= 1'b1;
            default: PHY_RX_ERROR <= 1'b1;
        endcase
        ID_QUADLET_DATA <= d;
        @(posedge SYS_CLK);
        {BUS_RESET_START, BUS_RESET_END, SUBACTION_GAP, ID_QUADLET_VALID, PHY_RX_ERROR} <= 5'h00;
        ID_QUADLET_DATA <= ~d;
        repeat (spc) @(posedge SYS_CLK);
    endtask
    // one identity phase of n quadlets; bad 1 breaks the phy, bad 2 fails host writes
    task automatic cap(input int n, input int bad);
        int nw;
        logic [8:0] nc;
        w0 = i_bicd_host_mem.n_wr;
        q.delete();
        BUS_TIME <= $urandom;
        fail <= (bad == 2);
        phy(0, 32'h0);
        gen_m++;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[10:2], 32'h0);
        phy(1, 32'h0);
        for (int k = 0; k < n; k++) begin
            q.push_back((k % 2) ? ~q[k - 1] : $urandom);
            if (bad == 1 && k == 2) phy(4, 32'h0);
            phy(3, q[k]);
        end
        phy(2, 32'h0);
        nw = (bad == 2) ? 1 : (bad == 1) ? 3 : (n >= 511) ? 512 : n + 1;
        nc = (bad == 2) ? 9'h0 : (n >= 511) ? 9'h1ff : nw[8:0]; // overflow mark in nine bits
        apb(1'b0, 12'h004, 32'h0);
        chk({rd[31], rd[23:16], rd[10:2]}, {bad != 0 || n >= 511, gen_m[7:0], nc});
        chk(i_bicd_host_mem.n_wr - w0, nw);
        if (bad == 0 && n < 511) begin
            chk(i_bicd_host_mem.mem[0], {8'h00, gen_m[7:0], BUS_TIME[27:12]});
            chk(i_bicd_host_mem.mem[0][23:16], rd[23:16]);
            for (int k = 0; k < n; k++) chk(i_bicd_host_mem.mem[k + 1], q[k]);
        end
    endtask
    initial begin
        {SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, fail} = 6'h0;
        {BUS_RESET_START, BUS_RESET_END, SUBACTION_GAP, ID_QUADLET_VALID, PHY_RX_ERROR} = 5'h0;
        {PADDR, PWDATA, ID_QUADLET_DATA, BUS_TIME} = 108'h0;
        {n_mismatch, checked, delay, gen_m} = 128'h0;
        spc = 8;
        void'($urandom(56));
        repeat (2) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        apb(1'b1, 12'h000, 32'h0001_2fff);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0001_2800);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd | {err_rd, 31'h0}, 32'h8000_0000);
        BUS_TIME <= $urandom;
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, BUS_TIME);
        apb(1'b1, 12'h008, 32'h0000_0200);
        apb(1'b1, 12'h010, 32'h3);
        cap(6, 0);
        chk(IRQ, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, 12'h00c, 32'h3);
        repeat (2) @(posedge SYS_CLK);
        chk(IRQ, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        delay <= 5;
        spc = 14;
        // a sequence cut short by a new bus reset, then recaptured
        phy(0, 32'h0);
        gen_m++;
        phy(1, 32'h0);
        phy(3, $urandom);
        cap(8, 0);
        cap(5, 1);
        cap(5, 2);
        delay <= 0;
        spc = 8;
        cap(6, 0);
        chk(IRQ, 32'h0);
        cap(520, 0);
        // accept bit off, then a quadlet outside the phase
        apb(1'b1, 12'h008, 32'h0);
        w0 = i_bicd_host_mem.n_wr;
        phy(0, 32'h0);
        gen_m++;
        phy(1, 32'h0);
        phy(3, $urandom);
        phy(2, 32'h0);
        q.push_back($urandom);
        phy(3, q[$]);
        chk(QUEUE_DATA, q[$]);
        chk(i_bicd_host_mem.n_wr - w0, 32'h0);
        spc = 1;
        for (int k = 0; k < 256; k++) phy(0, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd[23:16], gen_m[7:0]);
        end_of_test;
    end
endmodule // bicd_capture_bench
bind bicd_capture bicd_capture_chk i_bicd_capture_chk (.*);
